//--- usbps_pkg.sv
/*
 * Shared constants for the USB-serial power and status pin block:
 * register map, field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a plain one-cycle register port.
 */
package usbps_pkg;

	// Clock rate
	localparam int unsigned CLK_MHZ       = 100;

	// Register port
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam logic [7:0]  OFS_CFG       = 8'h00;  // Option bits, read/write
	localparam logic [7:0]  OFS_CTRL      = 8'h04;  // Handshake outputs, read/write
	localparam logic [7:0]  OFS_BAUD      = 8'h08;  // Clocks per serial bit, read/write
	localparam logic [7:0]  OFS_STATUS    = 8'h0C;  // Pin and engine state, read only

	// Option register fields
	localparam int          CFG_USB20     = 0;      // Report 2.0 descriptor
	localparam int          CFG_WAKE      = 1;      // Remote wakeup through ring input
	localparam int          CFG_PULLDN    = 2;      // Soft pull-down while power is off
	localparam logic [2:0]  CFG_RST       = 3'h0;

	// Handshake control fields (1 = asserted)
	localparam int          CTRL_DTR      = 0;
	localparam int          CTRL_RTS      = 1;
	localparam logic [1:0]  CTRL_RST      = 2'h0;

	// Serial bit period, reset value gives about 115200 baud
	localparam logic [15:0] BAUD_RST      = 16'h0364;

	// Status register fields
	localparam int          ST_CTS        = 0;
	localparam int          ST_DSR        = 1;
	localparam int          ST_DCD        = 2;
	localparam int          ST_RI         = 3;
	localparam int          ST_PSS        = 4;
	localparam int          ST_TXBUSY     = 5;
	localparam int          ST_LVL        = 8;

	// Descriptor release numbers
	localparam logic [15:0] BCD_USB20     = 16'h0200;
	localparam logic [15:0] BCD_USB11     = 16'h0110;

	// Pin synchroniser slots
	localparam int          NSYNC         = 7;
	localparam int          S_EXT         = 0;
	localparam int          S_RI          = 1;
	localparam int          S_PSS         = 2;
	localparam int          S_CTS         = 3;
	localparam int          S_DSR         = 4;
	localparam int          S_DCD         = 5;
	localparam int          S_RXD         = 6;

	// Timing
	localparam int unsigned POR_HIZ_MS    = 2;      // Reset output floats this long
	localparam int unsigned POR_CYC       = POR_HIZ_MS * CLK_MHZ * 1000;
	localparam int unsigned LED_PULSE_MS  = 10;     // Activity LED on-time
	localparam int unsigned LED_CYC       = LED_PULSE_MS * CLK_MHZ * 1000;
	localparam int          CNT_W         = 21;

	// Data path buffer
	localparam int          FIFO_W        = 8;
	localparam int          FIFO_D        = 8;
	localparam int          LVL_W         = 4;

	// Serial engine states
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_BUSY = 2'b10
	} usbps_tx_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_DATA = 3'b010,
		RX_HOLD = 3'b100
	} usbps_rx_t;

endpackage : usbps_pkg

//--- usbps_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides and a registered
 * output word. Assumes one clock, an active-low reset already synchronised,
 * and a synchronous clear from the owner.
 */
`timescale 1ns/10ps
module usbps_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 clr,
	input  wire logic                 in_valid,
	output logic                      in_ready,
	input  wire logic [W-1:0]         in_data,
	output logic                      out_valid,
	input  wire logic                 out_ready,
	output logic [W-1:0]              out_data,
	output logic [$clog2(D+1)-1:0]    level
);
	localparam int PW = $clog2(D);
	localparam int CW = $clog2(D+1);

	// Whole state: storage, pointers, count and the output register
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0]       wp;
		logic [PW-1:0]       rp;
		logic [CW-1:0]       cnt;
		logic                ov;
		logic [W-1:0]        od;
	} usbps_fifo_st_t;

	usbps_fifo_st_t q;
	usbps_fifo_st_t n;
	logic           push;
	logic           pop;

	// Full only counts the array; the output register adds one word of slack
	assign in_ready  = (q.cnt != CW'(D));
	assign push      = in_valid && in_ready;
	assign pop       = (!q.ov || out_ready) && (q.cnt != '0);
	assign out_valid = q.ov;
	assign out_data  = q.od;
	assign level     = q.cnt;

	// Next state: write, refill the output register, count
	always_comb
	begin
		n = q;
		if (out_ready)
		begin
			n.ov = 1'b0;
		end
		if (push)
		begin
			n.mem[q.wp] = in_data;
			n.wp        = q.wp + 1'b1;
		end
		if (pop)
		begin
			n.ov = 1'b1;
			n.od = q.mem[q.rp];
			n.rp = q.rp + 1'b1;
		end
		n.cnt = q.cnt + CW'(push) - CW'(pop);
		if (clr)
		begin
			// Flush drops everything including the staged word
			n.wp  = '0;
			n.rp  = '0;
			n.cnt = '0;
			n.ov  = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
		end
		else
		begin
			q <= n;
		end
	end

endmodule : usbps_fifo

//--- usbps_top.sv
/*
 * Power, reset and status pin logic of a USB-to-serial bridge, with the
 * host-to-serial byte path, a serial receiver and a small register port.
 * Assumes the USB engine sits on the same clock and reports configured,
 * suspend and bus reset as levels; all pin inputs are asynchronous.
 */
// Operation
// - option bit selects 2.0 descriptor, full speed
// - never claim high speed, always 12 Mb/s
// - board variant output driven high
// - reset output floats 2 ms, then drives
// - external reset low floats reset output
// - USB bus reset leaves reset output alone
// - suspend indicator low only during suspend
// - receive LED pulses low on USB receive
// - transmit LED pulses low on USB transmit
// - power enable low when configured, not suspended
// - RS485 enable high while serial transmitting
// - ring low resumes suspended host when enabled
// - drive DTR/RTS, take CTS/DSR/DCD inputs
// - send serial out, receive serial in
// - pull UART lines low while power off
`timescale 1ns/10ps
module usbps_top
	import usbps_pkg::*;
#(
	parameter int unsigned POR_CYCLES = usbps_pkg::POR_CYC,
	parameter int unsigned LED_CYCLES = usbps_pkg::LED_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic [usbps_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [usbps_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic [usbps_pkg::DATA_W-1:0]       reg_rdata,
	input  wire logic                          usb_configured,
	input  wire logic                          usb_suspend,
	input  wire logic                          usb_bus_reset,
	input  wire logic                          usb_rx_valid,
	output logic                               usb_rx_ready,
	input  wire logic [usbps_pkg::FIFO_W-1:0]  usb_rx_data,
	output logic                               usb_tx_valid,
	input  wire logic                          usb_tx_ready,
	output logic [usbps_pkg::FIFO_W-1:0]       usb_tx_data,
	output logic [15:0]                        usb_bcd_release,
	output logic                               usb_high_speed,
	output logic                               usb_resume_req,
	output logic                               board_variant_out,
	input  wire logic                          ext_reset_n,
	output logic                               por_output_n_o,
	output logic                               por_output_n_oe_n,
	output logic                               por_output_alias_n_o,
	output logic                               por_output_alias_n_oe_n,
	output logic                               suspend_ind_n,
	output logic                               rx_activity_led_n_o,
	output logic                               rx_activity_led_n_oe_n,
	output logic                               tx_activity_led_n_o,
	output logic                               tx_activity_led_n_oe_n,
	input  wire logic                          power_source_select,
	output logic                               external_power_enable_n,
	output logic                               external_power_enable_alias_n,
	output logic                               uart_pulldown_en,
	output logic                               rs485_driver_enable,
	input  wire logic                          ring_indicator_n,
	input  wire logic                          carrier_detect_n,
	input  wire logic                          dsr_n,
	input  wire logic                          cts_n,
	output logic                               dtr_n,
	output logic                               rts_n,
	input  wire logic                          serial_rxd,
	output logic                               serial_txd
);
	import usbps_pkg::*;

	localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYCLES - 1);
	localparam logic [CNT_W-1:0] LED_LOAD = CNT_W'(LED_CYCLES);

	// Whole state of the block
	typedef struct packed {
		logic [NSYNC-1:0] sy1;        // First synchroniser stage
		logic [NSYNC-1:0] sy2;        // Second synchroniser stage
		logic [CNT_W-1:0] por_cnt;    // Float-time counter
		logic             por_oe_n;   // Reset output floating
		logic [2:0]       cfg;
		logic [1:0]       ctrl;
		logic [15:0]      baud;
		logic [31:0]      rdata;
		logic [CNT_W-1:0] rxl_cnt;    // Receive LED on-time left
		logic [CNT_W-1:0] txl_cnt;    // Transmit LED on-time left
		logic             rxl_oe_n;
		logic             txl_oe_n;
		logic             susp_n;
		logic             pwr_n;
		logic             pulldn;
		logic             resume;
		logic             wake_done;  // One resume per suspend
		usbps_tx_t        tx_st;
		logic [9:0]       tx_sh;
		logic [3:0]       tx_bit;
		logic [15:0]      tx_baud;
		logic             txd;
		usbps_rx_t        rx_st;
		logic [7:0]       rx_sh;
		logic [3:0]       rx_bit;
		logic [15:0]      rx_baud;
	} usbps_st_t;

	usbps_st_t        q;
	usbps_st_t        n;
	logic [1:0]       rst_sy_ff;      // Reset release synchroniser
	logic             rst_n;
	logic             f_out_valid;
	logic             f_out_ready;
	logic [7:0]       f_out_data;
	logic [LVL_W-1:0] f_level;
	logic             push;
	logic             usb_tx_done;

	// End of a bit period; shared by both serial engines
	function automatic logic baud_hit(input logic [15:0] cnt, input logic [15:0] div);
		baud_hit = (cnt >= div - 16'h0001);
	endfunction : baud_hit

	// Release reset synchronously, assert it at once
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_sy_ff <= 2'h0;
		end
		else
		begin
			rst_sy_ff <= {rst_sy_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sy_ff[1];

	// Host-to-serial bytes wait here; a busy transmitter backs up the host
	usbps_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.clr       (!q.sy2[S_EXT]),
		.in_valid  (usb_rx_valid),
		.in_ready  (usb_rx_ready),
		.in_data   (usb_rx_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data),
		.level     (f_level)
	);

	assign push        = usb_rx_valid && usb_rx_ready;
	assign f_out_ready = (q.tx_st == TX_IDLE);
	assign usb_tx_valid = (q.rx_st == RX_HOLD);
	assign usb_tx_done = usb_tx_valid && usb_tx_ready;

	// Next-state logic
	always_comb
	begin
		n = q;
		// Every pin input passes two stages before use
		n.sy1 = {serial_rxd, carrier_detect_n, dsr_n, cts_n,
			power_source_select, ring_indicator_n, ext_reset_n};
		n.sy2 = q.sy1;
		n.rdata = '0;

		// Reset output: float, count, then drive; bus reset is not an input here
		if (!q.sy2[S_EXT])
		begin
			n.por_cnt  = '0;
			n.por_oe_n = 1'b1;
		end
		else if (q.por_oe_n)
		begin
			if (q.por_cnt == POR_LAST)
			begin
				n.por_oe_n = 1'b0;
			end
			else
			begin
				n.por_cnt = q.por_cnt + 1'b1;
			end
		end

		// Register writes
		if (reg_wr)
		begin
			case (reg_addr)
				OFS_CFG:  n.cfg  = reg_wdata[2:0];
				OFS_CTRL: n.ctrl = reg_wdata[1:0];
				OFS_BAUD: n.baud = reg_wdata[15:0];
				default:  ;     // Read-only or unmapped: ignored
			endcase
		end

		// Register reads, answered in the next cycle only
		if (reg_rd)
		begin
			case (reg_addr)
				OFS_CFG:    n.rdata[2:0]  = q.cfg;
				OFS_CTRL:   n.rdata[1:0]  = q.ctrl;
				OFS_BAUD:   n.rdata[15:0] = q.baud;
				OFS_STATUS:
				begin
					n.rdata[ST_CTS]    = !q.sy2[S_CTS];
					n.rdata[ST_DSR]    = !q.sy2[S_DSR];
					n.rdata[ST_DCD]    = !q.sy2[S_DCD];
					n.rdata[ST_RI]     = !q.sy2[S_RI];
					n.rdata[ST_PSS]    = q.sy2[S_PSS];
					n.rdata[ST_TXBUSY] = (q.tx_st == TX_BUSY);
					n.rdata[ST_LVL +: LVL_W] = f_level;
				end
				default:    n.rdata = '0;
			endcase
		end

		// Activity LEDs retrigger on each byte
		if (push)
		begin
			n.rxl_cnt = LED_LOAD;
		end
		else if (q.rxl_cnt != '0)
		begin
			n.rxl_cnt = q.rxl_cnt - 1'b1;
		end
		if (usb_tx_done)
		begin
			n.txl_cnt = LED_LOAD;
		end
		else if (q.txl_cnt != '0)
		begin
			n.txl_cnt = q.txl_cnt - 1'b1;
		end
		n.rxl_oe_n = (n.rxl_cnt == '0);
		n.txl_oe_n = (n.txl_cnt == '0);

		// Suspend and power switching
		n.susp_n = !usb_suspend;
		n.pwr_n  = !(usb_configured && !usb_suspend);
		n.pulldn = q.cfg[CFG_PULLDN] && q.pwr_n;

		// Remote wakeup: one resume request per suspend period
		n.resume = 1'b0;
		if (!usb_suspend)
		begin
			n.wake_done = 1'b0;
		end
		else if (q.cfg[CFG_WAKE] && !q.sy2[S_RI] && !q.wake_done)
		begin
			n.resume    = 1'b1;
			n.wake_done = 1'b1;
		end

		// Serial transmitter, 8N1
		unique case (q.tx_st)
			TX_IDLE:
			begin
				n.txd = 1'b1;
				if (f_out_valid)
				begin
					n.tx_sh   = {1'b1, f_out_data, 1'b0};
					n.tx_bit  = 4'h0;
					n.tx_baud = 16'h0000;
					n.tx_st   = TX_BUSY;
				end
			end
			TX_BUSY:
			begin
				n.txd     = q.tx_sh[0];
				n.tx_baud = q.tx_baud + 16'h0001;
				if (baud_hit(q.tx_baud, q.baud))
				begin
					n.tx_baud = 16'h0000;
					n.tx_sh   = {1'b1, q.tx_sh[9:1]};
					n.tx_bit  = q.tx_bit + 4'h1;
					if (q.tx_bit == 4'h9)
					begin
						n.tx_st = TX_IDLE;
					end
				end
			end
		endcase

		// Serial receiver: samples mid-bit; a byte waiting for USB blocks the next
		unique case (q.rx_st)
			RX_IDLE:
			begin
				if (!q.sy2[S_RXD])
				begin
					n.rx_baud = {1'b0, q.baud[15:1]};
					n.rx_bit  = 4'h0;
					n.rx_st   = RX_DATA;
				end
			end
			RX_DATA:
			begin
				n.rx_baud = q.rx_baud + 16'h0001;
				if (baud_hit(q.rx_baud, q.baud))
				begin
					n.rx_baud = 16'h0000;
					n.rx_bit  = q.rx_bit + 4'h1;
					if (q.rx_bit == 4'h0 && q.sy2[S_RXD])
					begin
						n.rx_st = RX_IDLE;     // Glitch, not a start bit
					end
					else if (q.rx_bit == 4'h9)
					begin
						// Framing error drops the byte
						n.rx_st = q.sy2[S_RXD] ? RX_HOLD : RX_IDLE;
					end
					else if (q.rx_bit != 4'h0)
					begin
						n.rx_sh = {q.sy2[S_RXD], q.rx_sh[7:1]};
					end
				end
			end
			RX_HOLD:
			begin
				if (usb_tx_ready)
				begin
					n.rx_st = RX_IDLE;
				end
			end
			default: n.rx_st = RX_IDLE;
		endcase

		// External reset returns the registers, resume logic and both serial engines to their reset state
		if (!q.sy2[S_EXT])
		begin
			n.cfg       = CFG_RST;
			n.ctrl      = CTRL_RST;
			n.baud      = BAUD_RST;
			n.resume    = 1'b0;
			n.wake_done = 1'b0;
			n.tx_st     = TX_IDLE;
			n.txd       = 1'b1;
			n.rx_st     = RX_IDLE;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q          <= '0;
			q.sy1      <= '1;
			q.sy2      <= '1;
			q.por_oe_n <= 1'b1;
			q.baud     <= BAUD_RST;
			q.rxl_oe_n <= 1'b1;
			q.txl_oe_n <= 1'b1;
			q.susp_n   <= 1'b1;
			q.pwr_n    <= 1'b1;
			q.tx_st    <= TX_IDLE;
			q.txd      <= 1'b1;
			q.rx_st    <= RX_IDLE;
		end
		else
		begin
			q <= n;
		end
	end

	// Outputs
	assign reg_rdata               = q.rdata;
	assign usb_tx_data             = q.rx_sh;
	assign usb_bcd_release         = q.cfg[CFG_USB20] ? BCD_USB20 : BCD_USB11;
	assign usb_high_speed          = 1'b0;
	assign usb_resume_req          = q.resume;
	assign board_variant_out       = 1'b1;
	assign por_output_n_o          = 1'b1;
	assign por_output_n_oe_n       = q.por_oe_n;
	assign por_output_alias_n_o    = 1'b1;
	assign por_output_alias_n_oe_n = q.por_oe_n;
	assign suspend_ind_n           = q.susp_n;
	assign rx_activity_led_n_o     = 1'b0;
	assign rx_activity_led_n_oe_n  = q.rxl_oe_n;
	assign tx_activity_led_n_o     = 1'b0;
	assign tx_activity_led_n_oe_n  = q.txl_oe_n;
	assign external_power_enable_n       = q.pwr_n;
	assign external_power_enable_alias_n = q.pwr_n;
	assign uart_pulldown_en        = q.pulldn;
	assign rs485_driver_enable     = (q.tx_st == TX_BUSY);
	assign dtr_n                   = !q.ctrl[CTRL_DTR];
	assign rts_n                   = !q.ctrl[CTRL_RTS];
	assign serial_txd              = q.txd;

	// Checks, all on the system clock
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_cfg_wr(logic v);
		reg_wr && reg_addr == OFS_CFG && reg_wdata[CFG_USB20] == v;
	endsequence
	sequence s_pop;
		f_out_valid && f_out_ready;
	endsequence

	property p_desc;
		s_cfg_wr(1'b1) ##0 q.sy2[S_EXT] |=> usb_bcd_release == BCD_USB20 && !usb_high_speed;
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor not 2.0");
	property p_fs;
		usb_high_speed == 1'b0 && board_variant_out == 1'b1;
	endproperty
	a_fs: assert property (p_fs) else $error("speed or variant wrong");
	property p_por;
		$fell(por_output_n_oe_n) |-> $past(q.por_cnt) == POR_LAST && $past(q.sy2[S_EXT]);
	endproperty
	a_por: assert property (p_por) else $error("reset output drove early");
	property p_ext;
		!q.sy2[S_EXT] |=> por_output_n_oe_n && q.por_cnt == '0;
	endproperty
	a_ext: assert property (p_ext) else $error("reset output not floated");
	property p_busrst;
		usb_bus_reset && !por_output_n_oe_n && q.sy2[S_EXT] |=> !por_output_n_oe_n;
	endproperty
	a_busrst: assert property (p_busrst) else $error("bus reset moved reset out");
	property p_susp;
		usb_suspend |=> !suspend_ind_n && external_power_enable_n;
	endproperty
	a_susp: assert property (p_susp) else $error("suspend outputs wrong");
	property p_pwr;
		usb_configured && !usb_suspend |=> !external_power_enable_n ##1 !uart_pulldown_en;
	endproperty
	a_pwr: assert property (p_pwr) else $error("power enable not low");
	property p_rx_activity_led_n;
		push |=> !rx_activity_led_n_oe_n [*2];
	endproperty
	a_rx_activity_led_n: assert property (p_rx_activity_led_n) else $error("rx led not pulsed");
	property p_tx_activity_led_n;
		usb_tx_done |=> !tx_activity_led_n_oe_n;
	endproperty
	a_tx_activity_led_n: assert property (p_tx_activity_led_n) else $error("tx led not pulsed");
	property p_drv;
		s_pop ##1 q.sy2[S_EXT] |-> rs485_driver_enable ##1 (rs485_driver_enable && !serial_txd);
	endproperty
	a_drv: assert property (p_drv) else $error("driver enable or start bit");
	property p_wake;
		usb_suspend && q.cfg[CFG_WAKE] && !q.sy2[S_RI] && !q.wake_done && q.sy2[S_EXT]
			|=> usb_resume_req ##1 !usb_resume_req;
	endproperty
	a_wake: assert property (p_wake) else $error("resume not single pulse");
	property p_pulldn;
		q.cfg[CFG_PULLDN] && external_power_enable_n |=> uart_pulldown_en;
	endproperty
	a_pulldn: assert property (p_pulldn) else $error("pull-down not applied");

endmodule : usbps_top

//--- usbps_partner.sv
/*
 * Target-side model: echoes the serial line and drives straps, ring,
 * reset and modem pins. Assumes the bench commands it by plain levels.
 */
`timescale 1ns/10ps
module usbps_partner (
	input  wire logic       serial_txd,
	input  wire logic       ring_req,
	input  wire logic       rst_req,
	input  wire logic [2:0] modem,
	output logic            serial_rxd,
	output logic            ring_indicator_n,
	output logic            ext_reset_n,
	output logic            power_source_select,
	output logic            cts_n,
	output logic            dsr_n,
	output logic            carrier_detect_n
);
	// Echo keeps both byte paths busy at once
	assign serial_rxd = serial_txd;
	// Reset held inactive unless asked for
	assign ext_reset_n = !rst_req;
	// Ring pulled low on request
	assign ring_indicator_n = !ring_req;
	// Board strapped as bus powered
	assign power_source_select = 1'h0;
	// Modem lines are active low
	assign {carrier_detect_n, dsr_n, cts_n} = ~modem;
endmodule : usbps_partner

//--- usbps_top_bench.sv
/*
 * Self-checking bench: registers, power pins, byte loopback through FIFO.
 * Assumes the partner echoes serial data and the USB side always takes.
 */
`timescale 1ns/10ps
module usbps_top_bench;
	import usbps_pkg::*;
	logic        clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic        cfgd = 1'h0, susp = 1'h0, busrst = 1'h0, rxv = 1'h0;
	logic        ring_req = 1'h0, rst_req = 1'h0, rd_q = 1'h0, tk = 1'h0;
	logic [7:0]  reg_addr = 8'h00, rxd8 = 8'h00, txd8;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [2:0]  modem = 3'h0;
	logic [15:0] bcd;
	logic        rxr, txv, hs, res, bv, por_oe, pa_oe, sus_n, rl_oe, tl_oe, pss;
	logic        pe_n, pea_n, pdn, de, ri_n, dcd_n, dsr_n, cts_n, dtr_n, rts_n;
	logic        srxd, stxd, ext_n, po, pao, rlo, tlo;
	int          bad_count = 0, cmp_count = 0;
	logic [31:0] rq[$];  // Expected read data
	logic [7:0]  sq[$];  // Bytes expected back from the echo

	// 100 MHz clock
	always #5 clk = ~clk;

	// Short counts keep the run brief
	usbps_top #(.POR_CYCLES(20), .LED_CYCLES(4)) u_usbps_top (
		.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.usb_configured(cfgd), .usb_suspend(susp), .usb_bus_reset(busrst),
		.usb_rx_valid(rxv), .usb_rx_ready(rxr), .usb_rx_data(rxd8),
		.usb_tx_valid(txv), .usb_tx_ready(1'h1), .usb_tx_data(txd8),
		.usb_bcd_release(bcd), .usb_high_speed(hs), .usb_resume_req(res),
		.board_variant_out(bv), .ext_reset_n(ext_n), .por_output_n_o(po),
		.por_output_n_oe_n(por_oe), .por_output_alias_n_o(pao),
		.por_output_alias_n_oe_n(pa_oe), .suspend_ind_n(sus_n),
		.rx_activity_led_n_o(rlo), .rx_activity_led_n_oe_n(rl_oe),
		.tx_activity_led_n_o(tlo), .tx_activity_led_n_oe_n(tl_oe),
		.power_source_select(pss), .external_power_enable_n(pe_n),
		.external_power_enable_alias_n(pea_n), .uart_pulldown_en(pdn),
		.rs485_driver_enable(de), .ring_indicator_n(ri_n),
		.carrier_detect_n(dcd_n), .dsr_n, .cts_n, .dtr_n, .rts_n,
		.serial_rxd(srxd), .serial_txd(stxd));

	usbps_partner u_usbps_partner (.serial_txd(stxd), .ring_req, .rst_req,
		.modem, .serial_rxd(srxd), .ring_indicator_n(ri_n), .ext_reset_n(ext_n),
		.power_source_select(pss), .cts_n, .dsr_n, .carrier_detect_n(dcd_n));

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic finish_test;
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr

	// One-cycle read; the monitor compares the answer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
	endtask : rd

	// Offer n random bytes back to back; valid holds while refused
	task automatic push(input int n);
		logic [7:0] b;
		logic       full;
		full = 1'h0;
		@(posedge clk);
		rxv <= 1'h1;
		repeat (n)
		begin
			b = 8'($urandom);
			rxd8 <= b;
			sq.push_back(b);
			@(negedge clk);
			while (rxr !== 1'h1)
			begin
				full = 1'h1;
				@(negedge clk);
			end
			@(posedge clk);
		end
		rxv <= 1'h0;
		#1 check(rl_oe, 0, "rx_led");
		check(full, n > 10, "refused");
	endtask : push

	// Monitor: read data, echoed bytes, transmit LED
	always @(posedge clk)
	begin
		if (rd_q)
			check(reg_rdata, rq.pop_front(), "rdata");
		if (tk)
			check(tl_oe, 0, "tx_led");
		if (txv)
			check(txd8, sq.pop_front(), "byte");
		rd_q <= reg_rd;
		tk <= txv;
	end

	// Main sequence
	initial
	begin
		void'($urandom(56389));
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		repeat (5) @(posedge clk);
		check(por_oe, 1, "por_float");
		check(bv, 1, "variant");
		check(hs, 0, "speed");
		rd(OFS_BAUD, 32'(BAUD_RST));
		rd(8'h10, 32'h0);
		for (int i = 1; i >= 0; i--)
		begin
			wr(OFS_CFG, 32'(i));
			#1 check(bcd, i ? BCD_USB20 : BCD_USB11, "bcd");
		end
		repeat (30) @(posedge clk);
		check({por_oe, pa_oe}, 0, "por_drive");
		check({po, pao}, 2'h3, "por_level");
		check({rlo, tlo}, 2'h0, "led_level");
		busrst <= 1'h1;
		repeat (3) @(posedge clk);
		busrst <= 1'h0;
		#1 check(por_oe, 0, "bus_reset");
		modem <= 3'($urandom);
		repeat (4) @(posedge clk);
		rd(OFS_STATUS, {29'h0, modem});
		wr(OFS_CTRL, 32'h3);
		#1 check({dtr_n, rts_n}, 0, "hs_out");
		wr(OFS_BAUD, 32'h10);
		push(1);
		push(12);
		check(de, 1, "rs485_on");
		for (int i = 0; i < 5000 && sq.size() > 0; i++)
			@(posedge clk);
		check(32'(sq.size()), 0, "drained");
		repeat (8) @(posedge clk);
		check(de, 0, "rs485_off");
		cfgd <= 1'h1;
		repeat (4) @(posedge clk);
		check({pe_n, pea_n, sus_n, pdn}, 4'h2, "awake");
		wr(OFS_CFG, 32'h6);
		susp <= 1'h1;
		ring_req <= 1'h1;
		for (int i = 0; i < 20 && res !== 1'h1; i++)
			@(negedge clk);
		check(res, 1, "resume");
		check({pe_n, pea_n, sus_n, pdn}, 4'hD, "asleep");
		@(posedge clk);
		rst_req <= 1'h1;
		repeat (6) @(posedge clk);
		check(por_oe, 1, "ext_reset");
		rst_req <= 1'h0;
		repeat (40) @(posedge clk);
		check(por_oe, 0, "por_again");
		finish_test;
	end

	// Watchdog well beyond the expected run
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test;
	end
endmodule : usbps_top_bench
